// ===== logic/scc_cfg.svh
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// Frame geometry
`define SCC_FRAME_BITS 5'h10
`define SCC_CNT_W 5
`define SCC_WORD_W 16
`define SCC_WORD_MSB 15
`define SCC_BYTE_W 8

// Control byte fields
`define SCC_CTRL_VREF_HI 7
`define SCC_CTRL_VREF_LO 5
`define SCC_CTRL_SHORT_EN 4
`define SCC_CTRL_STANDBY_BIT_ALIAS 3
`define SCC_CTRL_EN 2
`define SCC_CTRL_AMP_SD 1
`define SCC_CTRL_RESET 8'h00

// Status byte fields, low nibble unused and zero
`define SCC_ST_OVER 7
`define SCC_ST_SHORT 6
`define SCC_ST_TEMP 5
`define SCC_ST_READY 4
`define SCC_ST_RESET 8'h00

// Reference level mapping, percent
`define SCC_PCT_BASE 7'h1E
`define SCC_PCT_STEP 7'h0A
`define SCC_PCT_MAX 7'h64
`define SCC_CODE_MAX 3'h7

// Synchroniser lanes
`define SCC_SYNC_W 8
`define SCC_IN_SCK 0
`define SCC_IN_SSN 1
`define SCC_IN_MOSI 2
`define SCC_IN_OV 3
`define SCC_IN_SHORT 4
`define SCC_IN_THOT 5
`define SCC_IN_TCOOL 6
`define SCC_IN_READY 7
`define SCC_SYNC_RESET 8'h02

`endif

// ===== logic/scc_pkg.sv
`include "scc_cfg.svh"

package scc_pkg;

    // Link sequencing
    typedef enum logic [1:0] {
        SCC_LINK_IDLE,
        SCC_LINK_FRAME
    } scc_link_t;

    // Whole state of the control block
    typedef struct packed {
        scc_link_t linkState;
        logic [`SCC_WORD_W-1:0] shiftReg;
        logic [`SCC_CNT_W-1:0] bitCount;
        logic misoReg;
        logic misoOeN;
        logic sckPrev;
        logic ssPrev;
        logic [`SCC_BYTE_W-1:0] ctrlReg;
        logic overFlag;
        logic shortFlag;
        logic tempFlag;
        logic readyFlag;
        logic gateEnable;
        logic dutyRefReset;
        logic coreEnable;
        logic ampBiasEnable;
        logic [2:0] vrefCode;
        logic [6:0] vrefPercent;
    } scc_state_t;

    // Synchroniser state
    typedef struct packed {
        logic [`SCC_SYNC_W-1:0] stage1;
        logic [`SCC_SYNC_W-1:0] stage2;
    } scc_sync_t;

endpackage

// ===== logic/scc_sync.sv
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Raw inputs from pins
    input wire logic [`SCC_SYNC_W-1:0] asyncIn,
    // Inputs in the clk domain
    output logic [`SCC_SYNC_W-1:0] syncOut
);

    scc_pkg::scc_sync_t r;
    scc_pkg::scc_sync_t n;

    // Second stage alone reads the first
    always_comb begin
        n.stage1 = asyncIn;
        n.stage2 = r.stage1;
    end

    // Select line idles high, so its lane resets high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r.stage1 <= `SCC_SYNC_RESET;
            r.stage2 <= `SCC_SYNC_RESET;
        end else begin
            r <= n;
        end
    end

    assign syncOut = r.stage2;

endmodule

// ===== logic/scc_spi_ctrl.sv
// Notes on behaviour
// (RULE_01) Code 0..7 maps 30 to 100 percent
// (RULE_02) Overvoltage shuts the converter down
// (RULE_03) Overvoltage sets its status flag
// (RULE_04) Current sense trip suspends switching, flags short
// (RULE_05) Short protection acts only when enabled
// (RULE_06) Standby bit stops gate pulses only
// (RULE_07) Gate pulses need enable high, standby low
// (RULE_08) Enable low powers down all but wake-up
// (RULE_09) Wake-up logic keeps listening while disabled
// (RULE_10) Hot die sets temperature flag
// (RULE_11) Temperature flag clears below hysteresis threshold
// (RULE_12) Temperature flag takes no protective action
// (RULE_13) Enable or standby toggle resets duty reference
// (RULE_14) Sixteen-bit mode 0 frames, clock idles low
// (RULE_15) Select low presents status MSB first
// (RULE_16) Data sampled on serial clock rising edge
// (RULE_17) Next output bit shifted on falling edge
// (RULE_18) Returned word lags received word one frame
// (RULE_19) Only lower byte controls; upper carries status
// (RULE_20) Both lines carry most significant bit first
// (RULE_21) Ready flag shows high rail at level
// (RULE_22) Amplifier shutdown bit removes bias currents
// (RULE_23) Control applied only after complete frame
// (RULE_24) Status bit positions fixed, unused read zero
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_spi_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial port pins
    input wire logic spiSck,
    input wire logic spiSelN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOeN,
    // Analog monitor inputs
    input wire logic overvoltageTrip,
    input wire logic senseOverThreshold,
    input wire logic tempHot,
    input wire logic tempCool,
    input wire logic railReady,
    // Converter and amplifier controls
    output logic gateEnable,
    output logic dutyRefReset,
    output logic coreEnable,
    output logic ampBiasEnable,
    output logic [2:0] vrefCode,
    output logic [6:0] vrefPercent
);

    scc_pkg::scc_state_t r;
    scc_pkg::scc_state_t n;

    logic [`SCC_SYNC_W-1:0] syncIn;
    logic sckS;
    logic selNS;
    logic mosiS;
    logic ovS;
    logic shortS;
    logic hotS;
    logic coolS;
    logic readyS;
    logic inFrame;
    logic frameStart;
    logic frameEnd;
    logic frameFull;
    logic frameDone;
    logic sckRise;
    logic sckFall;
    logic modeToggle;
    logic [`SCC_BYTE_W-1:0] rxByte;
    logic [`SCC_BYTE_W-1:0] statusByte;
    logic [`SCC_WORD_W-1:0] txWord;

    // All pin and monitor levels cross into clk here
    scc_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({railReady, tempCool, tempHot, senseOverThreshold,
                  overvoltageTrip, spiMosi, spiSelN, spiSck}),
        .syncOut(syncIn)
    );

    // Named lanes of the synchronised inputs
    assign sckS = syncIn[`SCC_IN_SCK];
    assign selNS = syncIn[`SCC_IN_SSN];
    assign mosiS = syncIn[`SCC_IN_MOSI];
    assign ovS = syncIn[`SCC_IN_OV];
    assign shortS = syncIn[`SCC_IN_SHORT];
    assign hotS = syncIn[`SCC_IN_THOT];
    assign coolS = syncIn[`SCC_IN_TCOOL];
    assign readyS = syncIn[`SCC_IN_READY];

    // Edge and frame events, all from second-stage values
    assign inFrame = (r.linkState == scc_pkg::SCC_LINK_FRAME);
    assign frameStart = r.ssPrev & ~selNS;
    assign frameEnd = ~r.ssPrev & selNS;
    assign sckRise = sckS & ~r.sckPrev; // see (RULE_16)
    assign sckFall = ~sckS & r.sckPrev; // see (RULE_17)
    assign frameFull = (r.bitCount == `SCC_FRAME_BITS); // see (RULE_14)
    assign frameDone = inFrame & frameEnd & frameFull; // see (RULE_23)
    assign rxByte = r.shiftReg[`SCC_BYTE_W-1:0]; // see (RULE_19)
    assign modeToggle = (rxByte[`SCC_CTRL_EN] != r.ctrlReg[`SCC_CTRL_EN])
                      | (rxByte[`SCC_CTRL_STANDBY_BIT_ALIAS] != r.ctrlReg[`SCC_CTRL_STANDBY_BIT_ALIAS]);

    // Status byte: fixed flag slots, low nibble zero
    always_comb begin
        statusByte = `SCC_ST_RESET; // see (RULE_24)
        statusByte[`SCC_ST_OVER] = r.overFlag;
        statusByte[`SCC_ST_SHORT] = r.shortFlag;
        statusByte[`SCC_ST_TEMP] = r.tempFlag;
        statusByte[`SCC_ST_READY] = r.readyFlag; // see (RULE_21)
    end

    // Lower byte echoes the last applied control, hence one frame of lag
    assign txWord = {statusByte, r.ctrlReg}; // see (RULE_18)

    // Next-state logic for the whole block
    always_comb begin
        n = r;
        n.dutyRefReset = 1'b0;
        n.sckPrev = sckS;
        n.ssPrev = selNS;
        // Serial link sequencing; never gated by enable, so it doubles as wake-up
        case (r.linkState)
            scc_pkg::SCC_LINK_IDLE: begin
                if (frameStart) begin
                    n.linkState = scc_pkg::SCC_LINK_FRAME;
                    n.shiftReg = txWord;
                    n.bitCount = '0;
                    n.misoReg = txWord[`SCC_WORD_MSB]; // see (RULE_15)
                    n.misoOeN = 1'b0;
                end
            end
            scc_pkg::SCC_LINK_FRAME: begin
                if (frameEnd) begin
                    n.linkState = scc_pkg::SCC_LINK_IDLE;
                    n.misoOeN = 1'b1;
                    n.misoReg = 1'b0;
                    // Short frames are dropped whole
                    if (frameFull) begin
                        n.ctrlReg = rxByte; // see (RULE_23) (RULE_09)
                        n.dutyRefReset = modeToggle; // see (RULE_13)
                    end
                end else if (sckRise && !frameFull) begin
                    // MSB first in and out through one register
                    n.shiftReg = {r.shiftReg[`SCC_WORD_MSB-1:0], mosiS}; // see (RULE_20)
                    n.bitCount = r.bitCount + `SCC_CNT_W'(1); // see (RULE_16)
                end else if (sckFall && r.bitCount != '0 && !frameFull) begin
                    n.misoReg = r.shiftReg[`SCC_WORD_MSB]; // see (RULE_17)
                end
            end
            default: begin
                n.linkState = scc_pkg::SCC_LINK_IDLE;
                n.misoOeN = 1'b1;
            end
        endcase

        // Sticky fault flags; a new trip beats the clear on report
        n.overFlag = ovS | (r.overFlag & ~frameDone); // see (RULE_03)
        n.shortFlag = (shortS & n.ctrlReg[`SCC_CTRL_SHORT_EN]) // see (RULE_04) (RULE_05)
                    | (r.shortFlag & ~frameDone);
        // Hysteresis: set when hot, hold until cool
        n.tempFlag = hotS | (r.tempFlag & ~coolS); // see (RULE_10) (RULE_11)
        n.readyFlag = readyS; // see (RULE_21)

        // Power stage gating; temperature deliberately left out
        n.gateEnable = n.ctrlReg[`SCC_CTRL_EN] & ~n.ctrlReg[`SCC_CTRL_STANDBY_BIT_ALIAS] // see (RULE_06) (RULE_07)
                     & ~n.overFlag // see (RULE_02)
                     & ~(n.shortFlag & n.ctrlReg[`SCC_CTRL_SHORT_EN]); // see (RULE_04) (RULE_12)
        n.coreEnable = n.ctrlReg[`SCC_CTRL_EN]; // see (RULE_08)
        // Amplifier bias needs the core powered as well
        n.ampBiasEnable = n.ctrlReg[`SCC_CTRL_EN] & ~n.ctrlReg[`SCC_CTRL_AMP_SD]; // see (RULE_22)
        n.vrefCode = n.ctrlReg[`SCC_CTRL_VREF_HI:`SCC_CTRL_VREF_LO];
        n.vrefPercent = `SCC_PCT_BASE + ({4'h0, n.vrefCode} * `SCC_PCT_STEP); // see (RULE_01)
    end

    // State register; control resets to disabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r.linkState <= scc_pkg::SCC_LINK_IDLE;
            r.shiftReg <= '0;
            r.bitCount <= '0;
            r.misoReg <= 1'b0;
            r.misoOeN <= 1'b1;
            r.sckPrev <= 1'b0;
            r.ssPrev <= 1'b1;
            r.ctrlReg <= `SCC_CTRL_RESET;
            r.overFlag <= 1'b0;
            r.shortFlag <= 1'b0;
            r.tempFlag <= 1'b0;
            r.readyFlag <= 1'b0;
            r.gateEnable <= 1'b0;
            r.dutyRefReset <= 1'b0;
            r.coreEnable <= 1'b0;
            r.ampBiasEnable <= 1'b0;
            r.vrefCode <= 3'h0;
            r.vrefPercent <= `SCC_PCT_BASE;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign spiMiso = r.misoReg;
    assign spiMisoOeN = r.misoOeN;
    assign gateEnable = r.gateEnable;
    assign dutyRefReset = r.dutyRefReset;
    assign coreEnable = r.coreEnable;
    assign ampBiasEnable = r.ampBiasEnable;
    assign vrefCode = r.vrefCode;
    assign vrefPercent = r.vrefPercent;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Frame steps
    sequence closeFull;
        inFrame && frameEnd && frameFull;
    endsequence

    sequence closeShort;
        inFrame && frameEnd && !frameFull;
    endsequence

    sequence openFrame;
        !inFrame && frameStart;
    endsequence

    vref_low_a: assert property ( // see (RULE_01)
        (r.vrefCode == 3'h0) |-> (r.vrefPercent == `SCC_PCT_BASE))
        else $error("Lowest code does not give base level");

    vref_top_a: assert property ( // see (RULE_01)
        (r.vrefCode == `SCC_CODE_MAX) |-> (r.vrefPercent == `SCC_PCT_MAX))
        else $error("Top code does not give full level");

    over_stop_a: assert property ( // see (RULE_02)
        ovS |=> (!r.gateEnable && r.overFlag))
        else $error("Overvoltage left gate running or unflagged");

    over_hold_a: assert property ( // see (RULE_03)
        (r.overFlag && !frameDone) |=> r.overFlag)
        else $error("Overvoltage flag dropped before report");

    short_trip_a: assert property ( // see (RULE_04)
        (shortS && r.ctrlReg[`SCC_CTRL_SHORT_EN] && !frameDone)
        |=> (r.shortFlag && !r.gateEnable))
        else $error("Short did not flag or suspend switching");

    short_off_a: assert property ( // see (RULE_05)
        (!r.ctrlReg[`SCC_CTRL_SHORT_EN] && !r.shortFlag && !frameDone) |=> !r.shortFlag)
        else $error("Short flagged while protection disabled");

    gate_mode_a: assert property ( // see (RULE_07)
        r.gateEnable |-> (r.ctrlReg[`SCC_CTRL_EN] && !r.ctrlReg[`SCC_CTRL_STANDBY_BIT_ALIAS]))
        else $error("Gate running outside full operation");

    core_off_a: assert property ( // see (RULE_08)
        !r.ctrlReg[`SCC_CTRL_EN] |-> (!r.coreEnable && !r.ampBiasEnable && !r.gateEnable))
        else $error("Circuitry left on while disabled");

    temp_set_a: assert property ( // see (RULE_10)
        hotS |=> r.tempFlag)
        else $error("Hot die not flagged");

    temp_hyst_a: assert property ( // see (RULE_11)
        (r.tempFlag && !coolS) |=> r.tempFlag)
        else $error("Temperature flag cleared above lower threshold");

    duty_pulse_a: assert property ( // see (RULE_13)
        (closeFull and modeToggle) |=> r.dutyRefReset ##1 !r.dutyRefReset)
        else $error("Mode toggle gave no single duty reset pulse");

    miso_first_a: assert property ( // see (RULE_15)
        openFrame |=> (r.misoReg == $past(r.overFlag)) && !r.misoOeN)
        else $error("Frame did not open with status MSB");

    shift_out_a: assert property ( // see (RULE_17)
        (inFrame && !frameEnd && sckFall && r.bitCount != '0 && !frameFull)
        |=> (r.misoReg == $past(r.shiftReg[`SCC_WORD_MSB])))
        else $error("Falling edge did not present next bit");

    ctrl_apply_a: assert property ( // see (RULE_23)
        closeFull |=> (r.ctrlReg == $past(rxByte)) && !inFrame)
        else $error("Full frame not applied to control");

    ctrl_drop_a: assert property ( // see (RULE_23)
        closeShort |=> $stable(r.ctrlReg) ##1 $stable(r.ctrlReg))
        else $error("Incomplete frame changed control");

    // One serial bit taken on a clock rise
    sequence takeBit;
        inFrame && !frameEnd && sckRise && !frameFull;
    endsequence

    standby_bit_alias_hold_a: assert property ( // see (RULE_06)
        (r.ctrlReg[`SCC_CTRL_STANDBY_BIT_ALIAS] && r.ctrlReg[`SCC_CTRL_EN])
        |-> (!r.gateEnable && r.coreEnable))
        else $error("Standby did not stop only the gate");

    gate_full_a: assert property ( // see (RULE_07)
        (r.ctrlReg[`SCC_CTRL_EN] && !r.ctrlReg[`SCC_CTRL_STANDBY_BIT_ALIAS] && !r.overFlag && !r.shortFlag)
        |-> r.gateEnable)
        else $error("Full operation gave no gate pulses");

    wake_up_a: assert property ( // see (RULE_09)
        (frameDone && !r.ctrlReg[`SCC_CTRL_EN] && rxByte[`SCC_CTRL_EN]) |=> r.coreEnable)
        else $error("Enable write did not wake the core");

    temp_quiet_a: assert property ( // see (RULE_12)
        r.tempFlag |-> (r.gateEnable == (r.ctrlReg[`SCC_CTRL_EN] && !r.ctrlReg[`SCC_CTRL_STANDBY_BIT_ALIAS]
        && !r.overFlag && !(r.shortFlag && r.ctrlReg[`SCC_CTRL_SHORT_EN]))))
        else $error("Temperature flag changed the gate");

    duty_quiet_a: assert property ( // see (RULE_13)
        !(frameDone && modeToggle) |=> !r.dutyRefReset)
        else $error("Duty reset pulsed without a mode toggle");

    idle_release_a: assert property ( // see (RULE_14)
        !inFrame |-> (r.misoOeN && !r.misoReg))
        else $error("Output driven outside a frame");

    sample_rise_a: assert property ( // see (RULE_16)
        takeBit |=> (r.shiftReg[0] == $past(mosiS)) && (r.bitCount == $past(r.bitCount) + 1'b1))
        else $error("Rising edge did not take the input bit");

    shift_msb_a: assert property ( // see (RULE_20)
        takeBit |=> (r.shiftReg[`SCC_WORD_MSB:1] == $past(r.shiftReg[`SCC_WORD_MSB-1:0])))
        else $error("Shift register did not move toward the top bit");

    echo_load_a: assert property ( // see (RULE_18)
        openFrame |=> (r.shiftReg[`SCC_BYTE_W-1:0] == $past(r.ctrlReg)))
        else $error("Frame did not return the applied control");

    status_load_a: assert property ( // see (RULE_19)
        openFrame |=> (r.shiftReg[`SCC_WORD_MSB:`SCC_BYTE_W] == $past(statusByte)))
        else $error("Upper byte did not carry the status");

    status_zero_a: assert property ( // see (RULE_24)
        openFrame |=> (r.shiftReg[`SCC_BYTE_W+`SCC_ST_READY-1:`SCC_BYTE_W] == '0))
        else $error("Unused status bits not zero");

    ready_follow_a: assert property ( // see (RULE_21)
        readyS |=> r.readyFlag)
        else $error("Ready level not reported");

    amp_bias_a: assert property ( // see (RULE_22)
        r.ctrlReg[`SCC_CTRL_AMP_SD] |-> !r.ampBiasEnable)
        else $error("Amplifier bias left on in shutdown");

endmodule

// ===== sim/scc_host_model.sv
`timescale 1ns/1ps

module scc_host_model (
    // Serial port pins
    output logic spiSck,
    output logic spiSelN,
    output logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoOeN
);
    logic lastMiso = 1'b0;
    logic misoLine;

    // Released line shows the inverse of its last level, never a stale copy
    always @(spiMiso or spiMisoOeN) begin
        if (!spiMisoOeN)
            lastMiso = spiMiso;
    end
    assign misoLine = spiMisoOeN ? ~lastMiso : spiMiso;

    // Clock idles low, select idles high
    initial begin
        spiSck = 1'b0;
        spiSelN = 1'b1;
        spiMosi = 1'b0;
    end

    // One frame of nBits; 7 ns skew keeps the link off the clk edges
    task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
        rx = 16'h0000;
        #7;
        spiSelN = 1'b0;
        #200;
        for (int i = 15; i > 15 - nBits; i--) begin
            spiMosi = tx[i];
            #100 spiSck = 1'b1;
            rx[i] = misoLine;
            #100 spiSck = 1'b0;
        end
        #100 spiSelN = 1'b1;
        spiMosi = ~spiMosi;
        #200;
    endtask
endmodule

// ===== sim/stepup_converter_spi_control_tb_top.sv
`timescale 1ns/1ps

module stepup_converter_spi_control_tb_top;
    logic clk, resetn, spiSck, spiSelN, spiMosi, spiMiso, spiMisoOeN;
    logic overTrip, senseOver, tempHot, tempCool, railReady;
    logic gateEnable, dutyRefReset, coreEnable, ampBiasEnable;
    logic [2:0] vrefCode;
    logic [6:0] vrefPercent;
    logic [7:0] lastCtrl;
    logic [15:0] rx;
    int nErrors = 0;
    int samplesChecked = 0;
    int nPulse = 0;
    int cycles = 0;

    scc_spi_ctrl dut_u (.clk(clk), .resetn(resetn), .spiSck(spiSck), .spiSelN(spiSelN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN),
        .overvoltageTrip(overTrip), .senseOverThreshold(senseOver), .tempHot(tempHot),
        .tempCool(tempCool), .railReady(railReady), .gateEnable(gateEnable),
        .dutyRefReset(dutyRefReset), .coreEnable(coreEnable),
        .ampBiasEnable(ampBiasEnable), .vrefCode(vrefCode), .vrefPercent(vrefPercent));

    scc_host_model host_u (.spiSck(spiSck), .spiSelN(spiSelN), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Pulse counter and hang guard
    always @(posedge clk) begin
        cycles++;
        if (dutyRefReset === 1'b1)
            nPulse++;
        if (cycles == 20000) begin
            nErrors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            nErrors++;
        end
    endtask

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Outputs expected from a control byte with no trip pending
    task automatic chkOut(input logic [7:0] c);
        logic [6:0] pct;
        pct = 7'h1E + 7'h0A * {4'h0, c[7:5]};
        chk("outputs", {3'b000, c[2] & ~c[3], c[2], c[2] & ~c[1], c[7:5], pct},
            {3'b000, gateEnable, coreEnable, ampBiasEnable, vrefCode, vrefPercent});
    endtask

    // Full frame; junk upper byte, echo, status and duty pulse judged
    task automatic send(input logic [7:0] c, input logic [7:0] st);
        int p0;
        p0 = nPulse;
        @(posedge clk);
        host_u.xfer({8'hA5, c}, 16, rx);
        chk("echo", {8'h00, lastCtrl}, {8'h00, rx[7:0]});
        chk("status", {8'h00, st}, {8'h00, rx[15:8]});
        chk("dutyPulses", (c[3:2] != lastCtrl[3:2]) ? 16'h0001 : 16'h0000,
            16'(nPulse - p0));
        chk("misoRelease", 16'h0001, {15'h0000, spiMisoOeN});
        lastCtrl = c;
        // Back on a rising edge so later stimulus lands there
        @(posedge clk);
    endtask

    task automatic t_levels();
        for (int k = 0; k < 8; k++) begin
            send({k[2:0], 5'b00100}, 8'h00);
            chkOut(lastCtrl);
        end
        $display("t_levels done");
    endtask

    task automatic t_modes();
        logic [7:0] tbl [4] = '{8'hE8, 8'hE0, 8'hE6, 8'hE4};
        foreach (tbl[i]) begin
            send(tbl[i], 8'h00);
            chkOut(tbl[i]);
        end
        $display("t_modes done");
    endtask

    task automatic t_over();
        overTrip <= 1'b1;
        waitClk(4);
        chk("gateOver", 16'h0000, {15'h0000, gateEnable});
        send(8'hE4, 8'h80);
        overTrip <= 1'b0;
        send(8'hE4, 8'h80);
        send(8'hE4, 8'h00);
        chkOut(8'hE4);
        $display("t_over done");
    endtask

    task automatic t_short();
        senseOver <= 1'b1;
        waitClk(4);
        chkOut(8'hE4);
        send(8'hF4, 8'h00);
        waitClk(4);
        chk("gateShort", 16'h0000, {15'h0000, gateEnable});
        senseOver <= 1'b0;
        send(8'hF4, 8'h40);
        send(8'hE4, 8'h00);
        chkOut(8'hE4);
        $display("t_short done");
    endtask

    task automatic t_temp();
        tempHot <= 1'b1;
        waitClk(4);
        chkOut(8'hE4);
        tempHot <= 1'b0;
        send(8'hE4, 8'h20);
        send(8'hE4, 8'h20);
        tempCool <= 1'b1;
        waitClk(4);
        send(8'hE4, 8'h00);
        tempCool <= 1'b0;
        railReady <= 1'b1;
        waitClk(4);
        send(8'hE4, 8'h10);
        railReady <= 1'b0;
        $display("t_temp done");
    endtask

    task automatic t_partial();
        @(posedge clk);
        host_u.xfer(16'h00E8, 8, rx);
        chkOut(8'hE4);
        send(8'hE4, 8'h00);
        $display("t_partial done");
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        overTrip = 1'b0;
        senseOver = 1'b0;
        tempHot = 1'b0;
        tempCool = 1'b0;
        railReady = 1'b0;
        lastCtrl = 8'h00;
        waitClk(2);
        resetn <= 1'b1;
        waitClk(3);
        chk("resetOut", 16'h801E, {spiMisoOeN, spiMiso, gateEnable, coreEnable,
            ampBiasEnable, dutyRefReset, vrefCode, vrefPercent});
        $display("t_reset done");
        t_levels();
        t_modes();
        t_over();
        t_short();
        t_temp();
        t_partial();
        complete_run();
    end
endmodule
